// [pkg/trunk_event_cfg.svh]
`ifndef TRUNK_EVENT_CFG_SVH
`define TRUNK_EVENT_CFG_SVH

// ----------------------------------------------------------------
// Register pages
// ----------------------------------------------------------------
`define PAGE_MASTER 4'h1
`define PAGE_STATUS 4'h4
`define PAGE_HDLC0 4'hb
`define PAGE_HDLC1 4'hc
`define PAGE_HDLC2 4'hd

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_HDLC_MASK 5'h16
`define OFS_HDLC_STATUS 5'h17
`define OFS_RESET_CTRL 5'h1a
`define OFS_WORD_ZERO 5'h1b
`define OFS_WORD_ONE 5'h1c
`define OFS_WORD_TWO 5'h1d
`define OFS_WORD_THREE 5'h1e

// ----------------------------------------------------------------
// Reset control word fields
// ----------------------------------------------------------------
`define BIT_SOFT_RESET 7
`define BIT_SUSPEND 6
`define BIT_ACK_TOGGLE 5

// ----------------------------------------------------------------
// Word layout and reset values
// ----------------------------------------------------------------
`define BIT_HDLC0_SUMMARY 7
`define BIT_HDLC2_SUMMARY 5
`define WORD_ONE_USED 8'hfe
`define WORD_ALL_USED 8'hff
`define MASK_RESET 8'h00
`define CTRL_RESET 8'h00
`define STATUS_RESET 8'h00
`define RDATA_UNMAPPED 8'h00

`endif

// [pkg/trunk_event_pkg.sv]
package trunk_event_pkg;

  typedef logic [7:0] byte_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] page;
    logic [4:0] addr;
    byte_type wdata;
  } host_req_type;

  typedef struct packed {
    byte_type [3:0] word_mask;
    byte_type [2:0] hdlc_mask;
    byte_type ctrl;
    byte_type rdata;
  } unit_state_type;

  typedef struct packed {
    byte_type status;
  } sticky_state_type;

endpackage : trunk_event_pkg

// [hdl/sticky_event_word.sv]
`timescale 1ns/10ps
`include "trunk_event_cfg.svh"

module sticky_event_word
  import trunk_event_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Event side
  input wire byte_type events,
  input wire byte_type enable,
  // Clears
  input wire logic read_clear,
  input wire logic global_clear,
  // Latched flags
  output byte_type status
);

  sticky_state_type state_reg;
  sticky_state_type state_next;

  // ----------------------------------------------------------------
  // Latch
  // ----------------------------------------------------------------
  // A new event in the clearing cycle survives the clear.
  always_comb begin
    state_next = state_reg;
    if (read_clear || global_clear) begin
      state_next.status = `STATUS_RESET;
    end
    state_next.status = state_next.status | (events & enable);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg.status <= `STATUS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign status = state_reg.status;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_masked_no_set: assert property (
    ##1 (status & ~$past(status) & ~$past(events & enable)) == 8'h00)
    else $error("masked event set a flag");

  a_sticky_hold: assert property (
    !(read_clear || global_clear) |=> (status & $past(status)) == $past(status))
    else $error("flag dropped without a clear");

  a_read_clear: assert property (
    read_clear && ((events & enable) == 8'h00) |=> status == 8'h00)
    else $error("read did not clear word");

endmodule : sticky_event_word

// [hdl/trunk_event_interrupt_unit.sv]
`timescale 1ns/10ps
`include "trunk_event_cfg.svh"

module trunk_event_interrupt_unit
  import trunk_event_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Microprocessor port
  input wire host_req_type host_req,
  output byte_type host_rdata,
  // Framer and HDLC event pulses
  input wire byte_type [3:0] frame_events,
  input wire byte_type [2:0] hdlc_events,
  // Global clear pin
  input wire logic tx_all_ones_pin,
  // Open-drain interrupt request
  input wire logic irq_n_in,
  output logic irq_n_out,
  output logic irq_n_oe
);

  unit_state_type state_reg;
  unit_state_type state_next;

  byte_type [3:0] word_status;
  byte_type [3:0] word_events;
  byte_type [3:0] word_enable;
  byte_type [2:0] hdlc_status;
  logic [3:0] word_read;
  logic [2:0] hdlc_read;
  logic [2:0] hdlc_pending;
  logic ctrl_write;
  logic ack_toggle;
  logic soft_reset;
  logic global_clear;
  logic any_pending;
  logic suspend;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hits(input host_req_type req, input logic [3:0] page,
                                input logic [4:0] addr);
    hits = (req.page == page) && (req.addr == addr);
  endfunction : hits

  function automatic logic [3:0] hdlc_page(input int unsigned chan);
    case (chan)
      0: hdlc_page = `PAGE_HDLC0;
      1: hdlc_page = `PAGE_HDLC1;
      default: hdlc_page = `PAGE_HDLC2;
    endcase
  endfunction : hdlc_page

  function automatic logic [4:0] word_offset(input int unsigned idx);
    word_offset = `OFS_WORD_ZERO + 5'(idx);
  endfunction : word_offset

  assign ctrl_write = host_req.wr && hits(host_req, `PAGE_MASTER, `OFS_RESET_CTRL);
  assign ack_toggle = ctrl_write &&
    (host_req.wdata[`BIT_ACK_TOGGLE] != state_reg.ctrl[`BIT_ACK_TOGGLE]);
  assign soft_reset = ctrl_write && host_req.wdata[`BIT_SOFT_RESET];
  assign global_clear = ack_toggle || !tx_all_ones_pin || soft_reset;
  assign suspend = state_reg.ctrl[`BIT_SUSPEND];

  // ----------------------------------------------------------------
  // Clear-on-read strobes
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      word_read[i] = host_req.rd && hits(host_req, `PAGE_STATUS, word_offset(i));
    end
    for (int c = 0; c < 3; c++) begin
      hdlc_read[c] = host_req.rd && hits(host_req, hdlc_page(c), `OFS_HDLC_STATUS);
    end
  end

  // ----------------------------------------------------------------
  // Event routing
  // ----------------------------------------------------------------
  // Word three carries the HDLC summaries in its top three bits; a
  // summary is held back in a global clear so it cannot refill the word
  // from the HDLC flags that are being cleared in the same cycle.
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      hdlc_pending[c] = |(hdlc_status[c] & state_reg.hdlc_mask[c]);
    end
    word_events = frame_events;
    for (int c = 0; c < 3; c++) begin
      word_events[3][`BIT_HDLC0_SUMMARY - c] = hdlc_pending[c] && !global_clear;
    end
    for (int i = 0; i < 4; i++) begin
      word_enable[i] = state_reg.word_mask[i];
    end
    word_enable[1] = state_reg.word_mask[1] & `WORD_ONE_USED;
  end

  // ----------------------------------------------------------------
  // Status words and HDLC status registers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_word
    sticky_event_word u_word (
      .clk(clk),
      .reset_n(reset_n),
      .events(word_events[i]),
      .enable(word_enable[i]),
      .read_clear(word_read[i]),
      .global_clear(global_clear),
      .status(word_status[i])
    );
  end

  // HDLC flags always latch; the HDLC mask only gates the summary.
  for (genvar c = 0; c < 3; c++) begin : g_hdlc
    sticky_event_word u_hdlc (
      .clk(clk),
      .reset_n(reset_n),
      .events(hdlc_events[c]),
      .enable(`WORD_ALL_USED),
      .read_clear(hdlc_read[c]),
      .global_clear(global_clear),
      .status(hdlc_status[c])
    );
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (host_req.wr) begin
      for (int i = 0; i < 4; i++) begin
        if (hits(host_req, `PAGE_MASTER, word_offset(i))) begin
          state_next.word_mask[i] = host_req.wdata;
        end
      end
      for (int c = 0; c < 3; c++) begin
        if (hits(host_req, hdlc_page(c), `OFS_HDLC_MASK)) begin
          state_next.hdlc_mask[c] = host_req.wdata;
        end
      end
      if (ctrl_write) begin
        state_next.ctrl = host_req.wdata;
        state_next.ctrl[`BIT_SOFT_RESET] = 1'b0;
      end
    end
    if (soft_reset) begin
      state_next.word_mask = {4{`MASK_RESET}};
      state_next.hdlc_mask = {3{`MASK_RESET}};
      state_next.ctrl = `CTRL_RESET;
    end
    if (host_req.rd) begin
      state_next.rdata = `RDATA_UNMAPPED;
      for (int i = 0; i < 4; i++) begin
        if (hits(host_req, `PAGE_MASTER, word_offset(i))) begin
          state_next.rdata = state_reg.word_mask[i];
        end
        if (word_read[i]) begin
          state_next.rdata = word_status[i];
        end
      end
      for (int c = 0; c < 3; c++) begin
        if (hits(host_req, hdlc_page(c), `OFS_HDLC_MASK)) begin
          state_next.rdata = state_reg.hdlc_mask[c];
        end
        if (hdlc_read[c]) begin
          state_next.rdata = hdlc_status[c];
        end
      end
      if (hits(host_req, `PAGE_MASTER, `OFS_RESET_CTRL)) begin
        state_next.rdata = state_reg.ctrl;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg.word_mask <= {4{`MASK_RESET}};
      state_reg.hdlc_mask <= {3{`MASK_RESET}};
      state_reg.ctrl <= `CTRL_RESET;
      state_reg.rdata <= `RDATA_UNMAPPED;
    end else begin
      state_reg <= state_next;
    end
  end

  assign host_rdata = state_reg.rdata;

  // ----------------------------------------------------------------
  // Interrupt request pin
  // ----------------------------------------------------------------
  // The pin only ever pulls low; the pull-up sets the idle level.
  assign any_pending = |{word_status[0], word_status[1], word_status[2],
                         word_status[3]};
  assign irq_n_out = 1'b0;
  assign irq_n_oe = any_pending && !suspend;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic no_events;
  assign no_events = (frame_events == 32'h0000_0000) && (hdlc_events == 24'h00_0000);

  sequence s_ack_write;
    ack_toggle && no_events;
  endsequence

  sequence s_all_quiet;
    (word_status == 32'h0000_0000) && (hdlc_status == 24'h00_0000);
  endsequence

  a_irq_release: assert property (
    (word_status == 32'h0000_0000) |-> !irq_n_oe)
    else $error("request driven with no flag set");

  a_irq_drive: assert property (
    (frame_events[0] & state_reg.word_mask[0]) != 8'h00 && !suspend && !global_clear
    && !ctrl_write |=> irq_n_oe && (word_status[0] != 8'h00))
    else $error("unmasked event did not raise request");

  a_ack_clear: assert property (
    s_ack_write |=> s_all_quiet ##0 !irq_n_oe)
    else $error("acknowledge toggle did not clear");

  a_pin_clear: assert property (
    !tx_all_ones_pin && no_events |=> s_all_quiet)
    else $error("pin clear left flags pending");

  a_reset_masked: assert property (
    reset_n && !$past(reset_n) |->
    (state_reg.word_mask == 32'h0000_0000) && (state_reg.hdlc_mask == 24'h00_0000))
    else $error("masks not cleared by reset");

  a_soft_reset: assert property (
    soft_reset && no_events |=> (state_reg.word_mask == 32'h0000_0000) && !irq_n_oe)
    else $error("soft reset left sources unmasked");

  a_suspend_quiet: assert property (
    suspend |-> !irq_n_oe)
    else $error("request driven while suspended");

  a_suspend_masks: assert property (
    ctrl_write && !soft_reset |=> $stable(state_reg.word_mask))
    else $error("control write altered mask words");

  a_word_read: assert property (
    word_read[0] && frame_events[0] == 8'h00 |=> word_status[0] == 8'h00
    ##0 host_rdata == $past(word_status[0]))
    else $error("status word read failed to clear");

  a_word_one_bit0: assert property (
    word_status[1][0] == 1'b0)
    else $error("unused bit of word one set");

  // ----------------------------------------------------------------
  // Register and channel checks
  // ----------------------------------------------------------------
  // Channel zero stands in for all three; the logic is one loop.
  sequence s_mask_zero_write;
    host_req.wr && hits(host_req, `PAGE_MASTER, `OFS_WORD_ZERO);
  endsequence

  a_mask_write: assert property (
    s_mask_zero_write |=> state_reg.word_mask[0] == $past(host_req.wdata))
    else $error("mask word zero write lost");

  a_hdlc_mask_write: assert property (
    host_req.wr && hits(host_req, `PAGE_HDLC0, `OFS_HDLC_MASK)
    |=> state_reg.hdlc_mask[0] == $past(host_req.wdata))
    else $error("channel zero mask write lost");

  a_hdlc_latch: assert property (
    hdlc_events[0] != 8'h00
    |=> (hdlc_status[0] & $past(hdlc_events[0])) == $past(hdlc_events[0]))
    else $error("channel zero event not latched");

  a_hdlc_summary: assert property (
    hdlc_pending[0] && state_reg.word_mask[3][`BIT_HDLC0_SUMMARY] && !global_clear
    |=> word_status[3][`BIT_HDLC0_SUMMARY])
    else $error("channel zero summary not raised");

  a_hdlc_gate: assert property (
    !hdlc_pending[0] && !word_status[3][`BIT_HDLC0_SUMMARY]
    |=> !word_status[3][`BIT_HDLC0_SUMMARY])
    else $error("masked channel raised its summary");

  a_hdlc_read: assert property (
    hdlc_read[0] && hdlc_events[0] == 8'h00 |=> hdlc_status[0] == 8'h00
    ##0 host_rdata == $past(hdlc_status[0]))
    else $error("channel status read failed to clear");

  a_word_three_low: assert property (
    (frame_events[3] & state_reg.word_mask[3] & 8'h1f) != 8'h00
    |=> (word_status[3] & 8'h1f) != 8'h00)
    else $error("word three event not latched");

  // Suspend only hides the request; flags keep latching underneath.
  a_suspend_latch: assert property (
    suspend && (frame_events[0] & state_reg.word_mask[0]) != 8'h00
    |=> word_status[0] != 8'h00)
    else $error("flag not latched while suspended");

  a_irq_low_only: assert property (
    irq_n_out == 1'b0)
    else $error("request pin drives high");

  a_irq_follow: assert property (
    (word_status != 32'h0000_0000) && !suspend |-> irq_n_oe)
    else $error("pending flag without request");

  a_soft_bit_clear: assert property (
    soft_reset |=> !state_reg.ctrl[`BIT_SOFT_RESET] && !suspend)
    else $error("soft reset bit stuck");

  a_pin_hold: assert property (
    !tx_all_ones_pin && no_events |=> !irq_n_oe)
    else $error("request left driven by pin clear");

endmodule : trunk_event_interrupt_unit

// [bench/host_port_model.sv]
`timescale 1ns/10ps

module host_port_model
  import trunk_event_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output host_req_type host_req,
  input wire byte_type host_rdata,
  // Request wire
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  output logic irq_line
);
  // The request wire has a pull-up, so it floats high once released.
  assign irq_line = irq_n_oe ? irq_n_out : 1'b1;

  initial begin
    host_req = '0;
  end

  task automatic write_reg(input logic [3:0] page, input logic [4:0] addr, input byte_type data);
    @(negedge clk);
    host_req = '{rd: 1'b0, wr: 1'b1, page: page, addr: addr, wdata: data};
    @(negedge clk);
    host_req.wr = 1'b0;
  endtask : write_reg

  task automatic read_reg(input logic [3:0] page, input logic [4:0] addr, output byte_type data);
    @(negedge clk);
    host_req = '{rd: 1'b1, wr: 1'b0, page: page, addr: addr, wdata: 8'h00};
    @(negedge clk);
    host_req.rd = 1'b0;
    data = host_rdata;
  endtask : read_reg
endmodule : host_port_model

// [bench/trunk_event_interrupt_unit_bench.sv]
`timescale 1ns/10ps
`include "trunk_event_cfg.svh"

module trunk_event_interrupt_unit_bench
  import trunk_event_pkg::*;
;
  logic clk;
  logic reset_n;
  host_req_type host_req;
  byte_type host_rdata;
  byte_type [3:0] frame_events;
  byte_type [2:0] hdlc_events;
  logic tx_all_ones_pin;
  logic irq_n_out;
  logic irq_n_oe;
  logic irq_line;
  byte_type d;
  byte_type exp_word [4] = '{8'hff, 8'hfe, 8'hff, 8'h1f};
  int error_cnt = 0;
  int total_checks = 0;

  trunk_event_interrupt_unit trunk_event_interrupt_unit_inst (
    .clk(clk), .reset_n(reset_n), .host_req(host_req), .host_rdata(host_rdata),
    .frame_events(frame_events), .hdlc_events(hdlc_events),
    .tx_all_ones_pin(tx_all_ones_pin), .irq_n_in(irq_line),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

  host_port_model host_port_model_inst (
    .clk(clk), .host_req(host_req), .host_rdata(host_rdata),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .irq_line(irq_line));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string name, input byte_type seen, input byte_type exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic irq_is(input logic exp);
    check("irq", {7'h00, irq_line}, {7'h00, exp});
  endtask : irq_is

  // Pulses one framer word and one HDLC channel for a single cycle.
  task automatic fire(input int w, input byte_type v, input int c, input byte_type h);
    @(negedge clk);
    frame_events[w] = v;
    hdlc_events[c] = h;
    @(negedge clk);
    frame_events = '0;
    hdlc_events = '0;
  endtask : fire

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    reset_n = 1'b0;
    frame_events = '0;
    hdlc_events = '0;
    tx_all_ones_pin = 1'b1;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    // ----------------------------------------------------------------
    // Masked after reset
    // ----------------------------------------------------------------
    host_port_model_inst.read_reg(`PAGE_MASTER, `OFS_WORD_ZERO, d);
    check("mask0", d, 8'h00);
    fire(0, 8'hff, 0, 8'h00);
    irq_is(1'b1);
    host_port_model_inst.read_reg(`PAGE_STATUS, `OFS_WORD_ZERO, d);
    check("word0", d, 8'h00);
    // ----------------------------------------------------------------
    // Every word: latch, hold, read clear, release
    // ----------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      host_port_model_inst.write_reg(`PAGE_MASTER, `OFS_WORD_ZERO + 5'(i), 8'hff);
      fire(i, 8'hff, 0, 8'h00);
      repeat (3) @(negedge clk);
      irq_is(1'b0);
      host_port_model_inst.read_reg(`PAGE_STATUS, `OFS_WORD_ZERO + 5'(i), d);
      check("word", d, exp_word[i]);
      irq_is(1'b1);
      host_port_model_inst.read_reg(`PAGE_STATUS, `OFS_WORD_ZERO + 5'(i), d);
      check("word_again", d, 8'h00);
      host_port_model_inst.read_reg(`PAGE_MASTER, `OFS_WORD_ZERO + 5'(i), d);
      check("mask", d, 8'hff);
    end
    // ----------------------------------------------------------------
    // Suspend, then acknowledge toggle
    // ----------------------------------------------------------------
    host_port_model_inst.write_reg(`PAGE_MASTER, `OFS_RESET_CTRL, 8'h40);
    fire(0, 8'h81, 0, 8'h00);
    irq_is(1'b1);
    host_port_model_inst.read_reg(`PAGE_MASTER, `OFS_WORD_ZERO, d);
    check("mask_susp", d, 8'hff);
    host_port_model_inst.write_reg(`PAGE_MASTER, `OFS_RESET_CTRL, 8'h00);
    irq_is(1'b0);
    host_port_model_inst.write_reg(`PAGE_MASTER, `OFS_RESET_CTRL, 8'h20);
    irq_is(1'b1);
    host_port_model_inst.read_reg(`PAGE_STATUS, `OFS_WORD_ZERO, d);
    check("word0_ack", d, 8'h00);
    // ----------------------------------------------------------------
    // Global clear pin
    // ----------------------------------------------------------------
    fire(2, 8'h3c, 0, 8'h00);
    irq_is(1'b0);
    @(negedge clk);
    tx_all_ones_pin = 1'b0;
    @(negedge clk);
    tx_all_ones_pin = 1'b1;
    irq_is(1'b1);
    host_port_model_inst.read_reg(`PAGE_STATUS, `OFS_WORD_TWO, d);
    check("word2_pin", d, 8'h00);
    // ----------------------------------------------------------------
    // HDLC channels and their summaries
    // ----------------------------------------------------------------
    for (int c = 0; c < 3; c++) begin
      host_port_model_inst.write_reg(`PAGE_HDLC0 + 4'(c), `OFS_HDLC_MASK, 8'h01);
      host_port_model_inst.read_reg(`PAGE_HDLC0 + 4'(c), `OFS_HDLC_MASK, d);
      check("hmask", d, 8'h01);
      fire(0, 8'h00, c, 8'h81);
      @(negedge clk);
      irq_is(1'b0);
      host_port_model_inst.read_reg(`PAGE_HDLC0 + 4'(c), `OFS_HDLC_STATUS, d);
      check("hstat", d, 8'h81);
      host_port_model_inst.read_reg(`PAGE_STATUS, `OFS_WORD_THREE, d);
      check("word3_sum", d, 8'h80 >> c);
      irq_is(1'b1);
    end
    // ----------------------------------------------------------------
    // Software reset masks everything again
    // ----------------------------------------------------------------
    host_port_model_inst.write_reg(`PAGE_MASTER, `OFS_RESET_CTRL, 8'h80);
    for (int i = 0; i < 4; i++) begin
      host_port_model_inst.read_reg(`PAGE_MASTER, `OFS_WORD_ZERO + 5'(i), d);
      check("mask_srst", d, 8'h00);
    end
    fire(1, 8'hff, 0, 8'h00);
    irq_is(1'b1);
    // ----------------------------------------------------------------
    // Hardware reset in mid-run masks everything again
    // ----------------------------------------------------------------
    host_port_model_inst.write_reg(`PAGE_MASTER, `OFS_WORD_ONE, 8'hff);
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    host_port_model_inst.read_reg(`PAGE_MASTER, `OFS_WORD_ONE, d);
    check("mask_hrst", d, 8'h00);
    fire(1, 8'hff, 0, 8'h00);
    irq_is(1'b1);
    end_of_test();
  end
endmodule : trunk_event_interrupt_unit_bench
